// ### shared/bfec_pkg.sv
package bfec_pkg;

  // Codeword geometry and generator.
  localparam int          CW_BITS      = 2112;
  localparam int          TC_BITS      = 65;
  localparam int          PAR_BITS     = 32;
  localparam logic [5:0]  PAR_SLOT     = 6'h20;
  localparam logic [7:0]  TC_FILL      = 8'h41;
  localparam logic [7:0]  PAR_FILL     = 8'h20;
  localparam logic [7:0]  OUT_FILL     = 8'h40;
  localparam logic [31:0] GEN_POLY     = 32'h00a00805;

  // Line scrambler taps and reset seed.
  localparam int          SCR_TAP_A    = 38;
  localparam int          SCR_TAP_B    = 57;
  localparam logic [57:0] SCR_SEED     = 58'h3ffffffffffffff;

  // Burst trapping limits.
  localparam int          BURST_MAX    = 11;
  localparam logic [11:0] TRAP_STEP    = 12'h040;
  localparam logic [11:0] TRAP_LAST    = 12'h800;
  localparam logic [11:0] DEG_MAX      = 12'h835;
  localparam int          CW_TOP_DEG   = 2111;

  // Block lock hysteresis.
  localparam logic [3:0]  GOOD_TO_LOCK = 4'h4;
  localparam logic [3:0]  BAD_TO_LOSE  = 4'h8;

  // Base page bit positions of the correction flags.
  localparam int          AN_ABILITY   = 46;
  localparam int          AN_REQUEST   = 47;

  // Clock and line figures.
  localparam real         CLK_MHZ      = 250.0;
  localparam real         FEC_CLK_MHZ  = 161.1;
  localparam real         LINE_GBPS    = 10.3125;

  typedef enum logic [1:0] {
    BFEC_HUNT = 2'b01,
    BFEC_LOCK = 2'b10
  } bfec_sync_t;

endpackage

// ### logic/bfec_codec.sv
module bfec_codec (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        fec_reset_i,
  input  wire logic [47:0] local_page_i,
  input  wire logic [47:0] partner_page_i,
  input  wire logic [63:0] tx_pcs_data_i,
  input  wire logic [1:0]  tx_pcs_sync_i,
  input  wire logic        tx_pcs_valid_i,
  output logic             tx_pcs_ready_o,
  output logic [63:0]      tx_pma_data_o,
  output logic [1:0]       tx_pma_sync_o,
  output logic             tx_pma_valid_o,
  input  wire logic [63:0] rx_pma_data_i,
  input  wire logic [1:0]  rx_pma_sync_i,
  input  wire logic        rx_pma_valid_i,
  output logic [63:0]      rx_pcs_data_o,
  output logic [1:0]       rx_pcs_sync_o,
  output logic             rx_pcs_valid_o,
  output logic             block_lock_o,
  output logic             fec_enabled_o,
  output logic             corrected_o,
  output logic             uncorrectable_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Serial division, first n bits of d in stream order.
  function automatic logic [31:0] crc_bits(input logic [31:0] r, input logic [64:0] d,
                                           input int n);
    logic [31:0] c;
    logic        fb;
    c  = r;
    fb = 1'b0;
    for (int k = 0; k < 65; k++) begin
      if (k < n) begin
        fb = d[k] ^ c[31];
        c  = {c[30:0], 1'b0} ^ (fb ? bfec_pkg::GEN_POLY : 32'h0);
      end
    end
    return c;
  endfunction

  // Parity goes out highest degree first.
  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] o;
    o = 32'h0;
    for (int k = 0; k < 32; k++) begin
      o[k] = v[31-k];
    end
    return o;
  endfunction

  // Additive scrambler: the same call scrambles and descrambles. Feedback from
  // the data would turn one line error into three spread errors, past any burst.
  function automatic logic [121:0] scr64(input logic [57:0] s, input logic [63:0] d);
    logic [57:0] st;
    logic [63:0] o;
    logic        fb;
    st = s;
    o  = 64'h0;
    fb = 1'b0;
    for (int k = 0; k < 64; k++) begin
      fb   = st[bfec_pkg::SCR_TAP_A] ^ st[bfec_pkg::SCR_TAP_B];
      o[k] = d[k] ^ fb;
      st   = {st[56:0], fb};
    end
    return {st, o};
  endfunction

  // Multiply a remainder by x^-1 modulo the generator.
  function automatic logic [31:0] divx(input logic [31:0] s);
    return s[0] ? (((s ^ bfec_pkg::GEN_POLY) >> 1) | 32'h80000000) : (s >> 1);
  endfunction

  // The serial remainder carries an extra x^32; removing it makes the trap
  // offset equal to the lowest degree of the burst.
  function automatic logic [31:0] divx32(input logic [31:0] s);
    logic [31:0] v;
    v = s;
    for (int k = 0; k < bfec_pkg::PAR_BITS; k++) begin
      v = divx(v);
    end
    return v;
  endfunction

  // Flip mask for transcoded word idx from a trapped burst.
  function automatic logic [64:0] fix_mask(input logic [11:0] deg, input logic [10:0] pat,
                                           input logic [4:0] idx);
    logic [64:0] m;
    int          q;
    int          lo;
    m  = 65'h0;
    lo = bfec_pkg::TC_BITS * int'(idx);
    for (int j = 0; j < bfec_pkg::BURST_MAX; j++) begin
      q = bfec_pkg::CW_TOP_DEG - int'(deg) - j;
      if (pat[j] && q >= lo && q < lo + bfec_pkg::TC_BITS) begin
        m[q-lo] = 1'b1;
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Enable from auto-negotiation pages.

  logic fec_on;
  logic clr;
  logic able_both;
  logic req_any;

  assign able_both = local_page_i[bfec_pkg::AN_ABILITY] & partner_page_i[bfec_pkg::AN_ABILITY];
  assign req_any   = local_page_i[bfec_pkg::AN_REQUEST] | partner_page_i[bfec_pkg::AN_REQUEST];
  // Any change of mode or the dedicated reset restarts both paths.
  assign clr       = fec_reset_i | ~fec_on;

  // Ability alone is not enough; one side must ask.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fec_on <= 1'b0;
    end else begin
      fec_on <= able_both & req_any;
    end
  end
  assign fec_enabled_o = fec_on;

  ////////////////////////////////////////////////////////////////////////
  // Transmit path. Everything here runs on clk_i.

  logic [127:0] tx_acc;
  logic [127:0] acc_s;
  logic [127:0] next_tx_acc;
  logic [7:0]   tx_fill;
  logic [7:0]   fill_s;
  logic [7:0]   next_tx_fill;
  logic [5:0]   tx_cnt;
  logic [31:0]  tx_crc;
  logic [57:0]  tx_scr;
  logic [64:0]  tc_word;
  logic         tx_go;
  logic         tx_take;
  logic         tx_par;

  // The parity slot stalls the source for one cycle per codeword, which
  // is exactly the room the saved sync bits freed on the line.
  assign tx_par         = tx_cnt == bfec_pkg::PAR_SLOT;
  assign tx_pcs_ready_o = fec_on ? ~tx_par : 1'b1;
  assign tx_take        = tx_pcs_valid_i & ~tx_par;
  assign tc_word        = {tx_pcs_data_i, tx_pcs_sync_i[1]};
  assign tx_go          = tx_fill >= bfec_pkg::OUT_FILL;

  // Drain 64 bits first, then append a transcoded word or the parity.
  always_comb begin
    acc_s        = tx_go ? {64'h0, tx_acc[127:64]} : tx_acc;
    fill_s       = tx_go ? tx_fill - bfec_pkg::OUT_FILL : tx_fill;
    next_tx_acc  = acc_s;
    next_tx_fill = fill_s;
    if (tx_par) begin
      next_tx_acc  = acc_s | ({96'h0, rev32(tx_crc)} << fill_s);
      next_tx_fill = fill_s + bfec_pkg::PAR_FILL;
    end else if (tx_take) begin
      next_tx_acc  = acc_s | ({63'h0, tc_word} << fill_s);
      next_tx_fill = fill_s + bfec_pkg::TC_FILL;
    end
  end

  // Word count and running parity of the codeword.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_acc  <= 128'h0;
      tx_fill <= 8'h0;
      tx_cnt  <= 6'h0;
      tx_crc  <= 32'h0;
    end else if (clr) begin
      tx_acc  <= 128'h0;
      tx_fill <= 8'h0;
      tx_cnt  <= 6'h0;
      tx_crc  <= 32'h0;
    end else begin
      tx_acc  <= next_tx_acc;
      tx_fill <= next_tx_fill;
      if (tx_par) begin
        tx_cnt <= 6'h0;
        tx_crc <= 32'h0;
      end else if (tx_take) begin
        tx_cnt <= tx_cnt + 6'h01;
        tx_crc <= crc_bits(tx_crc, tc_word, bfec_pkg::TC_BITS);
      end
    end
  end

  // Line side output: scrambled codeword, or the raw word in bypass.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_pma_data_o  <= 64'h0;
      tx_pma_sync_o  <= 2'h0;
      tx_pma_valid_o <= 1'b0;
      tx_scr         <= bfec_pkg::SCR_SEED;
    end else if (!fec_on) begin
      tx_pma_data_o  <= tx_pcs_data_i;
      tx_pma_sync_o  <= tx_pcs_sync_i;
      tx_pma_valid_o <= tx_pcs_valid_i;
      tx_scr         <= bfec_pkg::SCR_SEED;
    end else if (fec_reset_i) begin
      tx_pma_data_o  <= 64'h0;
      tx_pma_sync_o  <= 2'h0;
      tx_pma_valid_o <= 1'b0;
      tx_scr         <= bfec_pkg::SCR_SEED;
    end else begin
      tx_pma_sync_o  <= 2'h0;
      tx_pma_valid_o <= tx_go;
      if (tx_go) begin
        {tx_scr, tx_pma_data_o} <= scr64(tx_scr, tx_acc[63:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive gearbox, descrambler and syndrome.

  logic [191:0] rx_acc;
  logic [191:0] acc1;
  logic [191:0] acc2;
  logic [191:0] next_rx_acc;
  logic [7:0]   rx_fill;
  logic [7:0]   fill1;
  logic [7:0]   fill2;
  logic [7:0]   next_rx_fill;
  logic [7:0]   need;
  logic [5:0]   rx_idx;
  logic [31:0]  rx_crc;
  logic [31:0]  syn;
  logic [57:0]  rx_dscr;
  logic [57:0]  next_dscr;
  logic [63:0]  drx;
  logic [64:0]  rx_word;
  logic         rx_ext;
  logic         cw_done;
  logic         syn_bad;
  logic         slip_now;
  logic         slip_pend;
  logic         do_slip;
  logic [1:0]   rx_bank;
  logic [64:0]  mem [0:127];
  bfec_pkg::bfec_sync_t sync_st;

  assign need     = (rx_idx == bfec_pkg::PAR_SLOT) ? bfec_pkg::PAR_FILL : bfec_pkg::TC_FILL;
  assign rx_ext   = rx_fill >= need;
  assign rx_word  = rx_acc[64:0];
  assign cw_done  = rx_ext & (rx_idx == bfec_pkg::PAR_SLOT);
  assign syn      = crc_bits(rx_crc, rx_word, int'(need));
  assign syn_bad  = syn != 32'h0;
  assign slip_now = cw_done & syn_bad & (sync_st == bfec_pkg::BFEC_HUNT);

  // The descrambler steps per line word, so it needs no codeword alignment,
  // but it relies on both ends starting together from the clear.
  // A slip drops one bit; it may wait a cycle if the buffer is empty.
  always_comb begin
    {next_dscr, drx} = scr64(rx_dscr, rx_pma_data_i);
    acc1             = rx_ext ? rx_acc >> need : rx_acc;
    fill1            = rx_ext ? rx_fill - need : rx_fill;
    do_slip          = (slip_pend | slip_now) & (fill1 != 8'h0);
    acc2             = do_slip ? acc1 >> 1 : acc1;
    fill2            = do_slip ? fill1 - 8'h01 : fill1;
    next_rx_acc      = acc2;
    next_rx_fill     = fill2;
    if (rx_pma_valid_i) begin
      next_rx_acc  = acc2 | ({128'h0, drx} << fill2);
      next_rx_fill = fill2 + bfec_pkg::OUT_FILL;
    end
  end

  // Bit buffer, word index and per-codeword remainder.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_acc  <= 192'h0;
      rx_fill <= 8'h0;
      rx_idx  <= 6'h0;
      rx_crc  <= 32'h0;
      rx_bank <= 2'h0;
      rx_dscr <= bfec_pkg::SCR_SEED;
    end else if (clr) begin
      rx_acc  <= 192'h0;
      rx_fill <= 8'h0;
      rx_idx  <= 6'h0;
      rx_crc  <= 32'h0;
      rx_bank <= 2'h0;
      rx_dscr <= bfec_pkg::SCR_SEED;
    end else begin
      rx_acc  <= next_rx_acc;
      rx_fill <= next_rx_fill;
      if (rx_pma_valid_i) begin
        rx_dscr <= next_dscr;
      end
      if (cw_done) begin
        rx_idx  <= 6'h0;
        rx_crc  <= 32'h0;
        rx_bank <= rx_bank + 2'h1;
      end else if (rx_ext) begin
        rx_idx <= rx_idx + 6'h01;
        rx_crc <= syn;
      end
    end
  end

  // Four banks: one filling, one searched, one read out.
  always_ff @(posedge clk_i) begin
    if (rx_ext && !cw_done) begin
      mem[{rx_bank, rx_idx[4:0]}] <= rx_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block lock with hysteresis.

  logic [3:0] good_cnt;
  logic [3:0] bad_cnt;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_st   <= bfec_pkg::BFEC_HUNT;
      good_cnt  <= 4'h0;
      bad_cnt   <= 4'h0;
      slip_pend <= 1'b0;
    end else if (clr) begin
      sync_st   <= bfec_pkg::BFEC_HUNT;
      good_cnt  <= 4'h0;
      bad_cnt   <= 4'h0;
      slip_pend <= 1'b0;
    end else begin
      slip_pend <= (slip_pend | slip_now) & ~do_slip;
      if (cw_done) begin
        case (sync_st)
          bfec_pkg::BFEC_HUNT: begin
            bad_cnt <= 4'h0;
            if (syn_bad) begin
              good_cnt <= 4'h0;
            end else if (good_cnt == bfec_pkg::GOOD_TO_LOCK - 4'h1) begin
              good_cnt <= 4'h0;
              sync_st  <= bfec_pkg::BFEC_LOCK;
            end else begin
              good_cnt <= good_cnt + 4'h1;
            end
          end
          bfec_pkg::BFEC_LOCK: begin
            good_cnt <= 4'h0;
            if (!syn_bad) begin
              bad_cnt <= 4'h0;
            end else if (bad_cnt == bfec_pkg::BAD_TO_LOSE - 4'h1) begin
              bad_cnt <= 4'h0;
              sync_st <= bfec_pkg::BFEC_HUNT;
            end else begin
              bad_cnt <= bad_cnt + 4'h1;
            end
          end
          default: begin
            sync_st <= bfec_pkg::BFEC_HUNT;
          end
        endcase
      end
    end
  end
  assign block_lock_o = sync_st == bfec_pkg::BFEC_LOCK;

  ////////////////////////////////////////////////////////////////////////
  // Burst trapping: 64 steps of x^-1 per cycle, so one codeword time.

  logic [31:0] srch_s;
  logic [31:0] ts;
  logic [11:0] srch_base;
  logic [11:0] srch_deg;
  logic [11:0] t_deg;
  logic [11:0] out_deg;
  logic [10:0] srch_pat;
  logic [10:0] t_pat;
  logic [10:0] out_pat;
  logic [5:0]  t_off;
  logic [1:0]  srch_bank;
  logic [1:0]  out_bank;
  logic        t_f;
  logic        srch_on;
  logic        srch_dirty;
  logic        srch_found;
  logic        out_found;
  logic        out_bad;
  logic        out_start;

  // Trap where the shifted remainder fits in the low burst bits.
  always_comb begin
    ts    = srch_s;
    t_f   = 1'b0;
    t_off = 6'h0;
    t_pat = 11'h0;
    for (int k = 0; k < 64; k++) begin
      if (!t_f && ts[31:11] == 21'h0) begin
        t_f   = 1'b1;
        t_off = 6'(k);
        t_pat = ts[10:0];
      end
      ts = divx(ts);
    end
    t_deg = srch_base + {6'h0, t_off};
  end

  // A burst that would reach past the codeword start is not correctable.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {srch_on, srch_dirty, srch_found, out_found, out_bad, out_start} <= 6'h0;
      {srch_s, srch_base, srch_deg, srch_pat, srch_bank} <= 69'h0;
      {out_deg, out_pat, out_bank} <= 25'h0;
    end else if (clr) begin
      {srch_on, srch_dirty, srch_found, out_found, out_bad, out_start} <= 6'h0;
      {srch_s, srch_base, srch_deg, srch_pat, srch_bank} <= 69'h0;
      {out_deg, out_pat, out_bank} <= 25'h0;
    end else if (cw_done) begin
      out_start  <= block_lock_o;
      out_found  <= srch_found;
      out_bad    <= srch_dirty & ~srch_found;
      out_deg    <= srch_deg;
      out_pat    <= srch_pat;
      out_bank   <= srch_bank;
      srch_bank  <= rx_bank;
      srch_s     <= divx32(syn);
      srch_on    <= syn_bad;
      srch_dirty <= syn_bad;
      srch_found <= 1'b0;
      srch_base  <= 12'h0;
    end else begin
      out_start <= 1'b0;
      if (srch_on) begin
        srch_s    <= ts;
        srch_base <= srch_base + bfec_pkg::TRAP_STEP;
        if (t_f || srch_base == bfec_pkg::TRAP_LAST) begin
          srch_on <= 1'b0;
        end
        if (t_f && t_deg <= bfec_pkg::DEG_MAX) begin
          srch_found <= 1'b1;
          srch_deg   <= t_deg;
          srch_pat   <= t_pat;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive output: corrected words with rebuilt sync headers.

  logic [5:0]  out_cnt;
  logic        out_act;
  logic [64:0] rd_word;

  assign rd_word = mem[{out_bank, out_cnt[4:0]}] ^
                   (out_found ? fix_mask(out_deg, out_pat, out_cnt[4:0]) : 65'h0);

  // An uncorrectable codeword is marked with an invalid header on every word.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {out_act, out_cnt, corrected_o, uncorrectable_o} <= 9'h0;
      {rx_pcs_data_o, rx_pcs_sync_o, rx_pcs_valid_o} <= 67'h0;
    end else if (!fec_on) begin
      {out_act, out_cnt, corrected_o, uncorrectable_o} <= 9'h0;
      rx_pcs_data_o  <= rx_pma_data_i;
      rx_pcs_sync_o  <= rx_pma_sync_i;
      rx_pcs_valid_o <= rx_pma_valid_i;
    end else if (fec_reset_i) begin
      {out_act, out_cnt, corrected_o, uncorrectable_o} <= 9'h0;
      {rx_pcs_data_o, rx_pcs_sync_o, rx_pcs_valid_o} <= 67'h0;
    end else begin
      corrected_o     <= out_start & out_found;
      uncorrectable_o <= out_start & out_bad;
      rx_pcs_valid_o  <= out_act;
      if (out_start) begin
        out_act <= 1'b1;
        out_cnt <= 6'h0;
      end else if (out_act) begin
        rx_pcs_data_o <= rd_word[64:1];
        rx_pcs_sync_o <= out_bad ? 2'h3 : {rd_word[0], ~rd_word[0]};
        out_cnt       <= out_cnt + 6'h01;
        if (out_cnt == bfec_pkg::PAR_SLOT - 6'h01) begin
          out_act <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence seq_good_done;
    cw_done && !syn_bad;
  endsequence

  sequence seq_bad_done;
    cw_done && syn_bad;
  endsequence

  chk_enable_rule: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (able_both && req_any) |=> fec_enabled_o) else $error("enable not set");
  chk_enable_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !req_any |=> !fec_enabled_o) else $error("enable without request");
  chk_parity_slot: assert property (@(posedge clk_i) disable iff (!rst_n_i || clr)
    tx_par |-> !tx_pcs_ready_o ##1 (tx_cnt == 6'h0 && tx_crc == 32'h0))
    else $error("parity slot wrong");
  chk_tx_drain: assert property (@(posedge clk_i) disable iff (!rst_n_i || clr)
    tx_go |=> tx_pma_valid_o) else $error("gearbox did not drain");
  chk_bypass_tx: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !fec_on |=> tx_pma_data_o == $past(tx_pcs_data_i)) else $error("bypass altered data");
  chk_lock_gain: assert property (@(posedge clk_i) disable iff (!rst_n_i || clr)
    (sync_st == bfec_pkg::BFEC_HUNT && good_cnt == 4'h3) ##0 seq_good_done
    |=> block_lock_o) else $error("lock not gained");
  chk_lock_loss: assert property (@(posedge clk_i) disable iff (!rst_n_i || clr)
    (block_lock_o && bad_cnt == 4'h7) ##0 seq_bad_done |=> !block_lock_o)
    else $error("lock not lost");
  chk_slip_done: assert property (@(posedge clk_i) disable iff (!rst_n_i || clr)
    slip_now |=> ##[0:1] !slip_pend) else $error("slip stuck");
  chk_trap_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i || clr)
    $rose(srch_on) |-> ##[1:34] !srch_on) else $error("search too long");
  chk_sync_regen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_pcs_valid_o && fec_on) |-> rx_pcs_sync_o != 2'h0) else $error("bad header");

endmodule

// ### verif/bfec_link_model.sv
// Line model: the PMA turns the transmit words straight back into the receiver.
module bfec_link_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [63:0] tx_data_i,
  input  wire logic [1:0]  tx_sync_i,
  input  wire logic        tx_valid_i,
  input  wire logic [63:0] flip_i,
  output logic [63:0]      rx_data_o,
  output logic [1:0]       rx_sync_o,
  output logic             rx_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Between words the line shows the inverse of the last value, so every second idle cycle repeats stale data.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_data_o  <= '0;
      rx_sync_o  <= '0;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= tx_valid_i;
      rx_sync_o  <= tx_valid_i ? tx_sync_i : ~rx_sync_o;
      rx_data_o  <= tx_valid_i ? (tx_data_i ^ flip_i) : ~rx_data_o;
    end
  end
endmodule

// ### verif/backplane_fec_codec_tb_top.sv
module backplane_fec_codec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i;
  logic        rst_n_i;
  logic        fec_reset;
  logic [47:0] lpage;
  logic [47:0] ppage;
  logic [63:0] tx_data;
  logic [1:0]  tx_sync;
  logic        tx_valid;
  logic        tx_ready;
  logic [63:0] pma_data;
  logic [1:0]  pma_sync;
  logic        pma_valid;
  logic [63:0] ln_data;
  logic [1:0]  ln_sync;
  logic        ln_valid;
  logic [63:0] rx_data;
  logic [1:0]  rx_sync;
  logic        rx_valid;
  logic        block_lock;
  logic        fec_en;
  logic        corrected;
  logic        uncorr;
  logic [63:0] flip;
  int          num_errors;
  int          num_checks;

  //////////////////////////////////////////////////////////////////////////////
  // Free running 250 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  bfec_link_model link (.clk_i(clk_i), .rst_n_i(rst_n_i), .tx_data_i(pma_data),
    .tx_sync_i(pma_sync), .tx_valid_i(pma_valid), .flip_i(flip),
    .rx_data_o(ln_data), .rx_sync_o(ln_sync), .rx_valid_o(ln_valid));

  bfec_codec dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .fec_reset_i(fec_reset),
    .local_page_i(lpage), .partner_page_i(ppage), .tx_pcs_data_i(tx_data),
    .tx_pcs_sync_i(tx_sync), .tx_pcs_valid_i(tx_valid), .tx_pcs_ready_o(tx_ready),
    .tx_pma_data_o(pma_data), .tx_pma_sync_o(pma_sync), .tx_pma_valid_o(pma_valid),
    .rx_pma_data_i(ln_data), .rx_pma_sync_i(ln_sync), .rx_pma_valid_i(ln_valid),
    .rx_pcs_data_o(rx_data), .rx_pcs_sync_o(rx_sync), .rx_pcs_valid_o(rx_valid),
    .block_lock_o(block_lock), .fec_enabled_o(fec_en), .corrected_o(corrected),
    .uncorrectable_o(uncorr));

  //////////////////////////////////////////////////////////////////////////////
  // Word pattern: odd slots carry a control header so both headers are rebuilt.
  function automatic logic [65:0] wd(input int i);
    return {i[0] ? 2'b10 : 2'b01, 64'h0123456789abcdef ^ {8{i[7:0]}}};
  endfunction

  task automatic check_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic check_word(input string n, input logic [65:0] e, input logic [65:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Each row: expected enable, local able/request, partner able/request.
  task automatic t_negotiate();
    logic [4:0] tab [4];
    tab = '{5'b01010, 5'b11110, 5'b11011, 5'b00111};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      lpage <= {tab[k][2], tab[k][3], 46'h0};
      ppage <= {tab[k][0], tab[k][1], 46'h0};
      @(posedge clk_i);
      #1;
      check_bit("fec_enabled", tab[k][4], fec_en);
    end
    $display("test negotiate done");
  endtask

  // With correction off a word crosses each direction in one cycle.
  task automatic t_bypass();
    @(posedge clk_i);
    {tx_sync, tx_data} <= wd(5);
    tx_valid           <= 1'b1;
    @(posedge clk_i);
    tx_valid <= 1'b0;
    #1;
    check_word("tx_pma_word", wd(5), {pma_sync, pma_data});
    repeat (2) @(posedge clk_i);
    #1;
    check_word("rx_pcs_word", wd(5), {rx_sync, rx_data});
    $display("test bypass done");
  endtask

  // Sixteen codewords looped back, one line bit flipped once lock is held.
  task automatic t_stream();
    int   n;
    int   oi;
    int   ncor;
    int   nunc;
    int   ntx;
    logic        rdy;
    logic        last_rdy;
    logic [63:0] line0;
    line0    = '0;
    n        = 0;
    oi       = 0;
    ncor     = 0;
    nunc     = 0;
    ntx      = 0;
    last_rdy = 1'b1;
    @(posedge clk_i);
    lpage <= 48'hc000_0000_0000;
    ppage <= 48'h4000_0000_0000;
    @(posedge clk_i);
    tx_valid           <= 1'b1;
    {tx_sync, tx_data} <= wd(0);
    fork
      begin
        for (int c = 0; c < 600 && n < 512; c++) begin
          #1;
          rdy = tx_ready;
          check_bit("tx_ready", !(n % 32 == 0 && n > 0 && last_rdy), rdy);
          last_rdy = rdy;
          @(posedge clk_i);
          if (rdy) begin
            n++;
            {tx_sync, tx_data} <= wd(n % 32);
          end
          flip <= (n == 261 && rdy) ? 64'h0000_0000_0001_0000 : '0;
        end
        tx_valid <= 1'b0;
      end
      for (int g = 0; g < 720; g++) begin
        @(posedge clk_i);
        #1;
        if (pma_valid === 1'b1 && ntx == 0) line0 = pma_data;
        if (pma_valid === 1'b1) ntx++;
        if (corrected === 1'b1) ncor++;
        if (uncorr === 1'b1) nunc++;
        if (rx_valid === 1'b1) begin
          check_word("rx_word", wd(oi % 32), {rx_sync, rx_data});
          oi++;
        end
      end
    join
    // A stuck ready would leave the stream unfinished: stop here.
    if (n < 512) begin
      num_errors++;
      $display("[ERR] tx_takes expected 512 seen %0d", n);
      end_of_test();
    end
    check_bit("line_words_528", 1'b1, ntx == 528);
    check_bit("block_lock", 1'b1, block_lock);
    check_bit("corrected_once", 1'b1, ncor == 1);
    check_bit("no_uncorrectable", 1'b1, nunc == 0);
    check_bit("rx_words_256", 1'b1, oi >= 256);
    // Unscrambled, the first line word would be T0 then the payload's low 63 bits.
    check_bit("line_scrambled", 1'b1, line0 !== 64'h02468acf13579bde);
    $display("test stream done");
  endtask

  // One cycle of the dedicated clear drops lock at once.
  task automatic t_reset();
    @(posedge clk_i);
    fec_reset <= 1'b1;
    @(posedge clk_i);
    fec_reset <= 1'b0;
    #1;
    check_bit("lock_after_clear", 1'b0, block_lock);
    $display("test reset done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for three cycles, then every scenario in turn.
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_n_i    = 1'b0;
    fec_reset  = 1'b0;
    lpage      = '0;
    ppage      = '0;
    tx_data    = '0;
    tx_sync    = '0;
    tx_valid   = 1'b0;
    flip       = '0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_negotiate();
    t_bypass();
    t_stream();
    t_reset();
    end_of_test();
  end
endmodule
